//--- halt_recovery_pkg.sv
// Package: register map, status layout, timing constants and carriers for halt recovery
package halt_recovery_pkg;

  // APB register byte offsets
  localparam logic [7:0] CAUSE_OFFSET = 8'h00;
  localparam logic [7:0] CTRL_OFFSET = 8'h04;
  localparam logic [7:0] WAKE_EN_OFFSET = 8'h08;
  localparam logic [7:0] PORT_DATA_OFFSET = 8'h0c;
  localparam logic [7:0] POWER_OFFSET = 8'h10;
  localparam logic [7:0] BLOCK_EN_OFFSET = 8'h14;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h1c;

  // Reset cause word bit positions
  localparam int CAUSE_PIN_BIT = 0;
  localparam int CAUSE_WDOG_BIT = 1;
  localparam int CAUSE_HALT_BIT = 2;
  localparam int CAUSE_POWER_BIT = 3;

  // Control word bit positions
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_DBGRESET_BIT = 1;
  localparam int CTRL_WDOG_IRQ_BIT = 2;
  localparam int CTRL_IRQ_EN_BIT = 3;

  // Interrupt status bit positions
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_WDOG_BIT = 1;

  // Values loaded into the cause word on reset and on halt exit
  localparam logic [3:0] CAUSE_POWER_ON = 4'h8;
  localparam logic [3:0] CAUSE_PIN_RESET = 4'h1;
  localparam logic [3:0] CAUSE_WDOG_RESET = 4'h2;
  localparam logic [3:0] CAUSE_PIN_WAKE = 4'h4;
  localparam logic [3:0] CAUSE_WDOG_WAKE = 4'h6;

  // Timing: recovery delay and shortest accepted wake pulse
  localparam int CLK_HZ = 10_000_000;
  localparam int RECOVERY_NS = 1000;
  localparam int MIN_PULSE_NS = 200;
  localparam int RECOVERY_CYCLES = (RECOVERY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MIN_PULSE_CYCLES = (MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Sequencer states, Gray coded along run -> halt -> recover
  typedef enum logic [1:0] {
    RUN = 2'b00,
    HALTED = 2'b01,
    RECOVER = 2'b11
  } seq_state_type;

  // Reset request travelling to the system
  typedef struct packed {
    logic request;
    logic [3:0] cause;
  } reset_req_type;

endpackage

//--- halt_recovery.sv
// Halt-state exit sequencer with reset cause word, pin wake sources and power gating
//
// Contract
// - Every halt exit through completed recovery sets the halt-exit flag.
// - Halted watchdog time-out in reset mode starts recovery, not system reset.
// - Halted watchdog time-out in interrupt mode recovers, then raises watchdog interrupt.
// - Pending watchdog interrupt is delivered only after recovery has finished.
// - Watchdog time-out while halted sets watchdog and halt-exit flags.
// - Each pin selectable as wake source; either edge while halted recovers.
// - Too-short wake pulse gives no recovery but still sets halt-exit flag.
// - Port data frozen while halted; captured only if level persists past recovery.
// - Reset pin while halted gives full system reset.
// - Debug pin low while halted gives full reset, cause reads power-up only.
// - Power-on and debugger reset give power-up flag only.
// - Reset pin gives pin-reset flag only.
// - Watchdog reset outside halt gives watchdog flag only.
// - Pin wake gives halt-exit flag only.
// - Halted watchdog wake gives halt-exit and watchdog flags.
// - A set power control bit disables its block whatever its enable bit says.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps

module halt_recovery #(
  parameter int PINS = 8,
  parameter int BLOCKS = 8
) (
  input wire logic core_clk, // System clock, 10 MHz
  input wire logic rst_n, // Asynchronous power-on reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [PINS-1:0] portPins, // General-purpose pin levels
  input wire logic watchdogTimeout, // Watchdog time-out pulse
  input wire logic resetPinLow, // External reset pin asserted, active low
  input wire logic debugPinIn, // Debug pin level
  output logic systemReset, // Full system reset request pulse
  output logic haltActive, // Clock-stopped state indicator
  output logic [BLOCKS-1:0] blockEnable, // Effective block enables
  output logic irq // Level interrupt
);

  initial
  begin
    if (PINS < 1 || PINS > 32 || BLOCKS < 1 || BLOCKS > 32)
    begin
      $error("halt_recovery: PINS and BLOCKS must lie in 1..32");
    end
  end

  localparam int CNT_W = 8;

  // Whole module state
  typedef struct packed {
    halt_recovery_pkg::seq_state_type seq;
    logic [3:0] cause;
    logic [3:0] ctrl;
    logic [PINS-1:0] wakeEn;
    logic [PINS-1:0] portData;
    logic [PINS-1:0] haltRef;
    logic [BLOCKS-1:0] power;
    logic [BLOCKS-1:0] blockEn;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic wdogPending;
    logic wdogWake;
    logic [CNT_W-1:0] pulseCnt;
    logic [CNT_W-1:0] recCnt;
    logic resetPinPrev;
    logic debugPrev;
    halt_recovery_pkg::reset_req_type rstReq;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irqOut;
    logic [BLOCKS-1:0] blockOut;
    logic haltOut;
  } state_type;

  state_type cur;
  state_type next_cur;

  // Address decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    return a == halt_recovery_pkg::CAUSE_OFFSET || a == halt_recovery_pkg::CTRL_OFFSET
      || a == halt_recovery_pkg::WAKE_EN_OFFSET || a == halt_recovery_pkg::PORT_DATA_OFFSET
      || a == halt_recovery_pkg::POWER_OFFSET || a == halt_recovery_pkg::BLOCK_EN_OFFSET
      || a == halt_recovery_pkg::IRQ_STATUS_OFFSET || a == halt_recovery_pkg::IRQ_MASK_OFFSET;
  endfunction

  logic setup;
  logic wr;
  logic [PINS-1:0] pinDiff;
  logic [BLOCKS-1:0] gated;
  logic [1:0] irqSet;

  assign setup = psel && !penable;
  assign wr = psel && penable && cur.ready && pwrite;
  assign pinDiff = (portPins ^ cur.haltRef) & cur.wakeEn;

  // Power bit overrides block enable
  genvar g;
  generate
    for (g = 0; g < BLOCKS; g++)
    begin : gate_gen
      assign gated[g] = cur.blockEn[g] & ~cur.power[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////

  // Next-state logic: bus, sequencer, cause word, interrupts
  always_comb
  begin
    next_cur = cur;
    irqSet = 2'b00;
    next_cur.resetPinPrev = resetPinLow;
    next_cur.debugPrev = debugPinIn;
    next_cur.rstReq.request = 1'b0;
    next_cur.ready = 1'b0;
    next_cur.slverr = 1'b0;

    // APB: no wait state, answer in first access cycle
    if (setup)
    begin
      next_cur.ready = 1'b1;
      next_cur.slverr = !mapped(paddr);
      next_cur.rdata = 32'h0;
      case (paddr)
        halt_recovery_pkg::CAUSE_OFFSET: next_cur.rdata[3:0] = cur.cause;
        halt_recovery_pkg::CTRL_OFFSET: next_cur.rdata[3:0] = cur.ctrl;
        halt_recovery_pkg::WAKE_EN_OFFSET: next_cur.rdata[PINS-1:0] = cur.wakeEn;
        halt_recovery_pkg::PORT_DATA_OFFSET: next_cur.rdata[PINS-1:0] = cur.portData;
        halt_recovery_pkg::POWER_OFFSET: next_cur.rdata[BLOCKS-1:0] = cur.power;
        halt_recovery_pkg::BLOCK_EN_OFFSET: next_cur.rdata[BLOCKS-1:0] = cur.blockEn;
        halt_recovery_pkg::IRQ_STATUS_OFFSET: next_cur.rdata[1:0] = cur.irqStatus;
        halt_recovery_pkg::IRQ_MASK_OFFSET: next_cur.rdata[1:0] = cur.irqMask;
        default: next_cur.rdata = 32'h0;
      endcase
    end
    if (wr)
    begin
      case (paddr)
        halt_recovery_pkg::CTRL_OFFSET: next_cur.ctrl = pwdata[3:0];
        halt_recovery_pkg::WAKE_EN_OFFSET: next_cur.wakeEn = pwdata[PINS-1:0];
        halt_recovery_pkg::POWER_OFFSET: next_cur.power = pwdata[BLOCKS-1:0];
        halt_recovery_pkg::BLOCK_EN_OFFSET: next_cur.blockEn = pwdata[BLOCKS-1:0];
        halt_recovery_pkg::IRQ_STATUS_OFFSET: next_cur.irqStatus = cur.irqStatus & ~pwdata[1:0];
        halt_recovery_pkg::IRQ_MASK_OFFSET: next_cur.irqMask = pwdata[1:0];
        default: next_cur.irqMask = next_cur.irqMask;
      endcase
    end

    // Port data follows pins only while running
    if (cur.seq == halt_recovery_pkg::RUN)
    begin
      next_cur.portData = portPins;
    end

    // Sequencer
    case (cur.seq)
      halt_recovery_pkg::RUN:
      begin
        if (!resetPinLow && cur.resetPinPrev)
        begin
          next_cur.rstReq = '{1'b1, halt_recovery_pkg::CAUSE_PIN_RESET};
        end
        else if (watchdogTimeout && !cur.ctrl[halt_recovery_pkg::CTRL_WDOG_IRQ_BIT])
        begin
          next_cur.rstReq = '{1'b1, halt_recovery_pkg::CAUSE_WDOG_RESET};
        end
        else if (wr && paddr == halt_recovery_pkg::CTRL_OFFSET
          && pwdata[halt_recovery_pkg::CTRL_DBGRESET_BIT])
        begin
          next_cur.rstReq = '{1'b1, halt_recovery_pkg::CAUSE_POWER_ON};
        end
        else if (watchdogTimeout)
        begin
          irqSet[halt_recovery_pkg::IRQ_WDOG_BIT] = 1'b1;
        end
        else if (wr && paddr == halt_recovery_pkg::CTRL_OFFSET
          && pwdata[halt_recovery_pkg::CTRL_HALT_BIT])
        begin
          next_cur.seq = halt_recovery_pkg::HALTED;
          next_cur.haltRef = portPins;
          next_cur.pulseCnt = '0;
        end
        next_cur.ctrl[halt_recovery_pkg::CTRL_HALT_BIT] = 1'b0;
        next_cur.ctrl[halt_recovery_pkg::CTRL_DBGRESET_BIT] = 1'b0;
      end
      halt_recovery_pkg::HALTED:
      begin
        if (!resetPinLow)
        begin
          next_cur.rstReq = '{1'b1, halt_recovery_pkg::CAUSE_PIN_RESET};
          next_cur.seq = halt_recovery_pkg::RUN;
        end
        else if (!debugPinIn && cur.debugPrev)
        begin
          next_cur.rstReq = '{1'b1, halt_recovery_pkg::CAUSE_POWER_ON};
          next_cur.seq = halt_recovery_pkg::RUN;
        end
        else if (watchdogTimeout)
        begin
          next_cur.seq = halt_recovery_pkg::RECOVER;
          next_cur.wdogWake = 1'b1;
          next_cur.wdogPending = cur.ctrl[halt_recovery_pkg::CTRL_WDOG_IRQ_BIT];
          next_cur.recCnt = '0;
        end
        else if (|pinDiff)
        begin
          if (cur.pulseCnt + 1'b1 >= CNT_W'(halt_recovery_pkg::MIN_PULSE_CYCLES))
          begin
            next_cur.seq = halt_recovery_pkg::RECOVER;
            next_cur.wdogWake = 1'b0;
            next_cur.recCnt = '0;
          end
          else
          begin
            next_cur.pulseCnt = cur.pulseCnt + 1'b1;
          end
        end
        else if (cur.pulseCnt != '0)
        begin
          // Pulse vanished too soon: stay halted but record the attempt
          next_cur.cause[halt_recovery_pkg::CAUSE_HALT_BIT] = 1'b1;
          next_cur.pulseCnt = '0;
        end
      end
      halt_recovery_pkg::RECOVER:
      begin
        if (!resetPinLow)
        begin
          next_cur.rstReq = '{1'b1, halt_recovery_pkg::CAUSE_PIN_RESET};
          next_cur.seq = halt_recovery_pkg::RUN;
        end
        else if (cur.recCnt + 1'b1 >= CNT_W'(halt_recovery_pkg::RECOVERY_CYCLES))
        begin
          next_cur.seq = halt_recovery_pkg::RUN;
          next_cur.cause = cur.wdogWake ? halt_recovery_pkg::CAUSE_WDOG_WAKE
            : halt_recovery_pkg::CAUSE_PIN_WAKE;
          next_cur.portData = portPins;
          irqSet[halt_recovery_pkg::IRQ_WAKE_BIT] = 1'b1;
          if (cur.wdogPending)
          begin
            irqSet[halt_recovery_pkg::IRQ_WDOG_BIT] = 1'b1;
            next_cur.wdogPending = 1'b0;
          end
        end
        else
        begin
          next_cur.recCnt = cur.recCnt + 1'b1;
        end
      end
      default: next_cur.seq = halt_recovery_pkg::RUN;
    endcase

    if (next_cur.rstReq.request)
    begin
      next_cur.cause = next_cur.rstReq.cause;
      next_cur.wdogPending = 1'b0;
    end

    // Sticky status: set wins over write-one clear
    next_cur.irqStatus = next_cur.irqStatus | irqSet;
    next_cur.irqOut = |(next_cur.irqStatus & next_cur.irqMask)
      && next_cur.ctrl[halt_recovery_pkg::CTRL_IRQ_EN_BIT];
    next_cur.blockOut = gated;
    // Registered halt indicator, high in HALTED and RECOVER
    next_cur.haltOut = next_cur.seq != halt_recovery_pkg::RUN;
  end

  ////////////////////////////////////////////////////////////////////////////////

  // State register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur <= '0;
      cur.seq <= halt_recovery_pkg::RUN;
      cur.cause <= halt_recovery_pkg::CAUSE_POWER_ON;
      cur.resetPinPrev <= 1'b1;
      cur.debugPrev <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Outputs straight from state
  assign prdata = cur.rdata;
  assign pready = cur.ready;
  assign pslverr = cur.slverr;
  assign systemReset = cur.rstReq.request;
  assign haltActive = cur.haltOut;
  assign blockEnable = cur.blockOut;
  assign irq = cur.irqOut;

endmodule

//--- halt_recovery_properties.sv
// Port checker for the halt recovery sequencer, with its bind
`timescale 1ns/1ps
module halt_recovery_checker (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic watchdogTimeout, // Time-out
  input wire logic resetPinLow, // Reset pin
  input wire logic debugPinIn, // Debug pin
  input wire logic systemReset, // Reset request
  input wire logic haltActive, // Halted
  input wire logic irq // Interrupt
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Bus answer timing
  ready_after_setup_a:
    assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_single_a:
    assert property (pready |=> !pready) else $error("ready held");
  error_with_ready_a:
    assert property (pslverr |-> pready) else $error("error without ready");
  // Wake and reset sources
  pin_reset_a:
    assert property ($fell(resetPinLow) && haltActive |-> ##[0:3] systemReset)
      else $error("no reset from reset pin");
  debug_reset_a:
    assert property ($fell(debugPinIn) && haltActive |-> ##[0:3] systemReset)
      else $error("no reset from debug pin");
  wdog_recover_a:
    assert property (watchdogTimeout && haltActive && resetPinLow && debugPinIn
      |=> !systemReset [*3]) else $error("watchdog wake reset the system");
  reset_pulse_a:
    assert property (systemReset |=> !systemReset) else $error("reset pulse too long");
  irq_after_exit_a:
    assert property ($rose(irq) |-> !haltActive) else $error("interrupt during recovery");
  recovery_long_a:
    assert property ($fell(haltActive) && !systemReset && !$past(systemReset)
      |-> $past(haltActive, 8)) else $error("recovery too short");
  // Main scenarios
  cover property ($fell(haltActive));
  cover property ($rose(irq));
  cover property (systemReset && haltActive);
endmodule
bind halt_recovery halt_recovery_checker u_halt_recovery_checker (.core_clk, .rst_n,
  .psel, .penable, .pready, .pslverr, .watchdogTimeout, .resetPinLow, .debugPinIn,
  .systemReset, .haltActive, .irq);

//--- far_side_model.sv
// Model of the pins, watchdog and reset sources around the sequencer
`timescale 1ns/1ps
module far_side_model (
  input wire logic core_clk, // Clock
  output logic [7:0] portPins, // Pin levels
  output logic watchdogTimeout, // Time-out pulse
  output logic resetPinLow, // Reset pin, active low
  output logic debugPinIn // Debug pin, pulled up when idle
);
  initial
  begin
    portPins = 8'h00;
    watchdogTimeout = 1'b0;
    resetPinLow = 1'b1;
    debugPinIn = 1'b1;
  end
  // One-cycle watchdog time-out
  task automatic wdog();
    @(posedge core_clk);
    watchdogTimeout <= 1'b1;
    @(posedge core_clk);
    watchdogTimeout <= 1'b0;
  endtask
  // Flip pins; with n above zero they flip back after n cycles
  task automatic pinFlip(input logic [7:0] m, input int n);
    @(posedge core_clk);
    portPins <= portPins ^ m;
    if (n > 0)
    begin
      repeat (n) @(posedge core_clk);
      portPins <= portPins ^ m;
    end
  endtask
  // Low pulse on the debug pin or the reset pin; both return high
  task automatic lowPulse(input logic dbg);
    @(posedge core_clk);
    if (dbg) debugPinIn <= 1'b0;
    else resetPinLow <= 1'b0;
    repeat (3) @(posedge core_clk);
    debugPinIn <= 1'b1;
    resetPinLow <= 1'b1;
  endtask
endmodule

//--- tb_halt_recovery.sv
// Self-checking bench for the halt recovery sequencer
`timescale 1ns/1ps
module tb_halt_recovery;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] portPins;
  logic watchdogTimeout;
  logic resetPinLow;
  logic debugPinIn;
  logic systemReset;
  logic haltActive;
  logic [7:0] blockEnable;
  logic irq;
  logic [31:0] rd;
  logic rdErr;
  int failCount = 0;
  int checks = 0;
  int cycles = 0;
  int resets = 0;
  always #50 core_clk = ~core_clk;
  halt_recovery u_halt_recovery (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .portPins, .watchdogTimeout, .resetPinLow,
    .debugPinIn, .systemReset, .haltActive, .blockEnable, .irq);
  far_side_model u_far_side_model (.core_clk, .portPins, .watchdogTimeout, .resetPinLow,
    .debugPinIn);
  ////////////////////////////////////////////////////////////////////////
  // Count reset requests and cut a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (systemReset === 1'b1) resets++;
    if (cycles == 20000)
    begin
      failCount++;
      wrapUp();
    end
  end
  // Verdict
  task automatic wrapUp();
    $display("Compares %0d, mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Value compare
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare under a mask
  task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    check(n, e, rd & m);
  endtask
  // Wait for the halt to end
  task automatic waitRun();
    repeat (100) if (haltActive === 1'b1) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk("cause", halt_recovery_pkg::CAUSE_OFFSET, 32'h8, 32'hf);
    apb(1'b0, 8'h40, 32'h0);
    check("slverr", 32'h1, {31'h0, rdErr});
    apb(1'b1, halt_recovery_pkg::BLOCK_EN_OFFSET, 32'hff);
    apb(1'b1, halt_recovery_pkg::POWER_OFFSET, 32'h0f);
    repeat (2) @(posedge core_clk);
    check("blocks", 32'hf0, {24'h0, blockEnable});
    // Pin wake: a disabled pin first, then an enabled one
    apb(1'b1, halt_recovery_pkg::WAKE_EN_OFFSET, 32'h01);
    apb(1'b1, halt_recovery_pkg::IRQ_MASK_OFFSET, 32'h03);
    apb(1'b1, halt_recovery_pkg::CTRL_OFFSET, 32'h09);
    u_far_side_model.pinFlip(8'h80, 0);
    repeat (20) @(posedge core_clk);
    check("halted", 32'h1, {31'h0, haltActive});
    // Short glitch on the enabled pin: stays halted, halt-exit flag still set
    u_far_side_model.pinFlip(8'h01, 1);
    repeat (20) @(posedge core_clk);
    check("halted", 32'h1, {31'h0, haltActive});
    rdChk("haltflag", halt_recovery_pkg::CAUSE_OFFSET, 32'h4, 32'h4);
    u_far_side_model.pinFlip(8'h01, 0);
    waitRun();
    rdChk("cause", halt_recovery_pkg::CAUSE_OFFSET, 32'h4, 32'hf);
    rdChk("port", halt_recovery_pkg::PORT_DATA_OFFSET, 32'h81, 32'hff);
    check("irq", 32'h1, {31'h0, irq});
    apb(1'b1, halt_recovery_pkg::IRQ_STATUS_OFFSET, 32'h3);
    repeat (2) @(posedge core_clk);
    check("irq", 32'h0, {31'h0, irq});
    // Watchdog in reset mode while halted
    apb(1'b1, halt_recovery_pkg::CTRL_OFFSET, 32'h01);
    u_far_side_model.wdog();
    waitRun();
    rdChk("cause", halt_recovery_pkg::CAUSE_OFFSET, 32'h6, 32'hf);
    check("resets", 32'h0, resets);
    // Watchdog in interrupt mode while halted
    apb(1'b1, halt_recovery_pkg::IRQ_STATUS_OFFSET, 32'h3);
    apb(1'b1, halt_recovery_pkg::CTRL_OFFSET, 32'h0d);
    u_far_side_model.wdog();
    check("irq", 32'h0, {31'h0, irq});
    waitRun();
    repeat (3) @(posedge core_clk);
    check("irq", 32'h1, {31'h0, irq});
    rdChk("wdstat", halt_recovery_pkg::IRQ_STATUS_OFFSET, 32'h2, 32'h2);
    // Reset pin while halted, then debugger reset
    apb(1'b1, halt_recovery_pkg::CTRL_OFFSET, 32'h01);
    u_far_side_model.lowPulse(1'b0);
    repeat (5) @(posedge core_clk);
    rdChk("cause", halt_recovery_pkg::CAUSE_OFFSET, 32'h1, 32'hf);
    check("resets", 32'h1, {31'h0, resets > 0});
    apb(1'b1, halt_recovery_pkg::CTRL_OFFSET, 32'h02);
    repeat (5) @(posedge core_clk);
    rdChk("cause", halt_recovery_pkg::CAUSE_OFFSET, 32'h8, 32'hf);
    // Watchdog outside halt, then debug pin while halted
    apb(1'b1, halt_recovery_pkg::CTRL_OFFSET, 32'h00);
    u_far_side_model.wdog();
    repeat (5) @(posedge core_clk);
    rdChk("cause", halt_recovery_pkg::CAUSE_OFFSET, 32'h2, 32'hf);
    apb(1'b1, halt_recovery_pkg::CTRL_OFFSET, 32'h01);
    u_far_side_model.lowPulse(1'b1);
    repeat (5) @(posedge core_clk);
    rdChk("cause", halt_recovery_pkg::CAUSE_OFFSET, 32'h8, 32'hf);
    wrapUp();
  end
endmodule
